/* logic/serdes_rx_sample_check_and_link_id.sv */
// Receive-side sample check, lane inversion and lane 0 link identifier capture
`timescale 1ns/100ps
module serdes_rx_sample_check_and_link_id #(
  parameter int LANES = 8,
  parameter int WORD = 40,
  parameter int CHANNELS = 4,
  parameter int SAMPLES = 16
) (
  input wire logic clock,
  input wire logic rst,
  input rx_check_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [LANES*WORD-1:0] lane_in,
  output logic [LANES*WORD-1:0] lane_out,
  input wire logic sample_valid,
  input wire logic [CHANNELS*SAMPLES*16-1:0] sample_in,
  input rx_check_pkg::link_cfg_s link_cfg,
  output logic check_mismatch_flag
);
  import rx_check_pkg::*;

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  // The select fields are only two and four bits wide
  if (LANES < 1 || LANES > 8)
  begin : gen_bad_lanes
    $error("LANES must be 1 to 8");
  end
  if (CHANNELS < 1 || CHANNELS > 4)
  begin : gen_bad_channels
    $error("CHANNELS must be 1 to 4");
  end
  if (SAMPLES < 1 || SAMPLES > 16)
  begin : gen_bad_samples
    $error("SAMPLES must be 1 to 16");
  end
  if (WORD < 1)
  begin : gen_bad_word
    $error("WORD must be at least 1");
  end

  // ***************************************************************
  // Software registers
  // ***************************************************************
  logic [3:0] check_sample_index_r;
  logic [1:0] check_channel_select_r;
  logic check_result_clear_r;
  logic check_enable_r;
  logic [7:0] expected_sample_low_r;
  logic [7:0] expected_sample_high_r;
  logic [7:0] lane_invert_bits_r;
  logic [7:0] received_device_ident_r;
  logic [7:0] received_bank_ident_r;
  logic mismatch_r;
  logic [7:0] reg_rdata_r;
  logic reg_rvalid_r;

  // Control byte: sample index, channel, clear and enable fields
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      check_sample_index_r <= RESET_BYTE[3:0];
      check_channel_select_r <= RESET_BYTE[1:0];
      check_result_clear_r <= 1'b0;
      check_enable_r <= 1'b0;
    end
    else if (reg_req.wr && reg_req.addr == OFS_CHECK_CONTROL)
    begin
      check_sample_index_r <= reg_req.wdata[SAMPLE_INDEX_MSB:SAMPLE_INDEX_LSB];
      check_channel_select_r <= reg_req.wdata[CHANNEL_SEL_MSB:CHANNEL_SEL_LSB];
      check_result_clear_r <= reg_req.wdata[RESULT_CLEAR_BIT];
      check_enable_r <= reg_req.wdata[CHECK_ENABLE_BIT];
    end
  end

  // Reference sample bytes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      expected_sample_low_r <= RESET_BYTE;
      expected_sample_high_r <= RESET_BYTE;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == OFS_REF_LOW)
      begin
        expected_sample_low_r <= reg_req.wdata;
      end
      else if (reg_req.addr == OFS_REF_HIGH)
      begin
        expected_sample_high_r <= reg_req.wdata;
      end
    end
  end

  // Lane inversion mask
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lane_invert_bits_r <= RESET_BYTE;
    end
    else if (reg_req.wr && reg_req.addr == OFS_LANE_INVERT)
    begin
      lane_invert_bits_r <= reg_req.wdata;
    end
  end

  // ***************************************************************
  // Lane 0 link configuration capture
  // ***************************************************************
  // Latest alignment configuration wins; a fresh link overwrites it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      received_device_ident_r <= RESET_BYTE;
      received_bank_ident_r <= RESET_BYTE;
    end
    else if (link_cfg.valid)
    begin
      received_device_ident_r <= link_cfg.device_ident;
      received_bank_ident_r <= link_cfg.bank_ident;
    end
  end

  // ***************************************************************
  // Transport sample check
  // ***************************************************************
  logic [15:0] reference;
  logic [15:0] picked_sample;
  logic pick_in_range;
  logic mismatch_seen;
  int pick_slot;

  assign reference = {expected_sample_high_r, expected_sample_low_r};

  // Out-of-range selections give no sample, so they never flag
  always_comb
  begin
    pick_slot = int'(check_channel_select_r) * SAMPLES + int'(check_sample_index_r);
    pick_in_range = (int'(check_channel_select_r) < CHANNELS)
      && (int'(check_sample_index_r) < SAMPLES);
    picked_sample = 16'h0000;
    if (pick_in_range)
    begin
      picked_sample = sample_in[pick_slot*16 +: 16];
    end
  end

  assign mismatch_seen = check_enable_r && sample_valid && pick_in_range
    && (picked_sample != reference);

  // Sticky fail flag; a mismatch in the clear cycle still sets it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mismatch_r <= 1'b0;
    end
    else if (mismatch_seen)
    begin
      mismatch_r <= 1'b1;
    end
    else if (check_result_clear_r)
    begin
      mismatch_r <= 1'b0;
    end
  end

  // ***************************************************************
  // Register read port
  // ***************************************************************
  // Read data lands one cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_r <= UNMAPPED_READ;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_req.rd;
      if (reg_req.rd)
      begin
        if (reg_req.addr == OFS_CHECK_CONTROL)
        begin
          reg_rdata_r <= {check_sample_index_r, check_channel_select_r,
            check_result_clear_r, check_enable_r};
        end
        else if (reg_req.addr == OFS_REF_LOW)
        begin
          reg_rdata_r <= expected_sample_low_r;
        end
        else if (reg_req.addr == OFS_REF_HIGH)
        begin
          reg_rdata_r <= expected_sample_high_r;
        end
        else if (reg_req.addr == OFS_CHECK_RESULT)
        begin
          reg_rdata_r <= {7'h00, mismatch_r};
        end
        else if (reg_req.addr == OFS_LANE_INVERT)
        begin
          reg_rdata_r <= lane_invert_bits_r;
        end
        else if (reg_req.addr == OFS_DEVICE_IDENT)
        begin
          reg_rdata_r <= received_device_ident_r;
        end
        else if (reg_req.addr == OFS_BANK_IDENT)
        begin
          reg_rdata_r <= received_bank_ident_r;
        end
        else
        begin
          reg_rdata_r <= UNMAPPED_READ;
        end
      end
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;
  assign check_mismatch_flag = mismatch_r;

  // ***************************************************************
  // Lane inversion
  // ***************************************************************
  lane_invert #(
    .LANES(LANES),
    .WORD(WORD)
  ) u_lane_invert (
    .clock(clock),
    .rst(rst),
    .lane_invert_bits(lane_invert_bits_r[LANES-1:0]),
    .lane_in(lane_in),
    .lane_out(lane_out)
  );

endmodule

/* logic/rx_check_pkg.sv */
// Package: register map, field layout and carrier types for the receive check block
// How it works
// - Bits 7:4 pick sample 0 to 15
// - Bits 3:2 pick converter channel 0 upward
// - Clear bit at one wipes check result, unless a mismatch is seen in the same cycle
// - Comparison runs only while enable is one
// - Writable low byte of expected sample
// - Writable high byte completes 16-bit reference
// - Read-only fail flag, one on mismatch
// - Eight bits each invert one lane
// - Bit n inverts logical lane n
// - Lane 0 device identifier captured, read-only
// - Lane 0 bank identifier captured, read-only
package rx_check_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [11:0] OFS_CHECK_CONTROL = 12'h32C;
  localparam logic [11:0] OFS_REF_LOW = 12'h32D;
  localparam logic [11:0] OFS_REF_HIGH = 12'h32E;
  localparam logic [11:0] OFS_CHECK_RESULT = 12'h32F;
  localparam logic [11:0] OFS_LANE_INVERT = 12'h334;
  localparam logic [11:0] OFS_DEVICE_IDENT = 12'h400;
  localparam logic [11:0] OFS_BANK_IDENT = 12'h401;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int SAMPLE_INDEX_LSB = 4;
  localparam int SAMPLE_INDEX_MSB = 7;
  localparam int CHANNEL_SEL_LSB = 2;
  localparam int CHANNEL_SEL_MSB = 3;
  localparam int RESULT_CLEAR_BIT = 1;
  localparam int CHECK_ENABLE_BIT = 0;
  localparam int MISMATCH_BIT = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] device_ident;
    logic [7:0] bank_ident;
  } link_cfg_s;

endpackage

/* logic/lane_invert.sv */
// Per-lane polarity inversion of deserialized receive data
`timescale 1ns/100ps
module lane_invert #(
  parameter int LANES = 8,
  parameter int WORD = 40
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [LANES-1:0] lane_invert_bits,
  input wire logic [LANES*WORD-1:0] lane_in,
  output logic [LANES*WORD-1:0] lane_out
);

  // ***************************************************************
  // Inversion stage
  // ***************************************************************
  // One flop stage per lane keeps the output registered
  for (genvar g = 0; g < LANES; g++)
  begin : gen_lane
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        lane_out[g*WORD +: WORD] <= '0;
      end
      else
      begin
        // Bit g only touches logical lane g
        lane_out[g*WORD +: WORD] <= lane_in[g*WORD +: WORD] ^ {WORD{lane_invert_bits[g]}};
      end
    end
  end

endmodule

/* testbench/rx_check_props.sv */
// Port checker for the receive check block
`timescale 1ns/100ps
module rx_check_props #(
  parameter int LANES = 8,
  parameter int WORD = 40,
  parameter int CHANNELS = 4,
  parameter int SAMPLES = 16
) (
  input wire logic clock,
  input wire logic rst,
  input rx_check_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [LANES*WORD-1:0] lane_in,
  input wire logic [LANES*WORD-1:0] lane_out,
  input wire logic sample_valid,
  input wire logic [CHANNELS*SAMPLES*16-1:0] sample_in,
  input rx_check_pkg::link_cfg_s link_cfg,
  input wire logic check_mismatch_flag
);
  import rx_check_pkg::*;
  logic [7:0] ctrl_r, lo_r, hi_r, inv_r;
  logic [7:0] dev_r, bank_r;
  logic [LANES*WORD-1:0] mask;
  logic [15:0] sel;
  logic hit, f, rd_only;
  // *****
  // Shadow state
  // *****
  // Writable bytes mirrored from the write strobe
  always_ff @(posedge clock or posedge rst)
    if (rst)
      {ctrl_r, lo_r, hi_r, inv_r} <= '0;
    else if (reg_req.wr)
      case (reg_req.addr)
        OFS_CHECK_CONTROL: ctrl_r <= reg_req.wdata;
        OFS_REF_LOW: lo_r <= reg_req.wdata;
        OFS_REF_HIGH: hi_r <= reg_req.wdata;
        OFS_LANE_INVERT: inv_r <= reg_req.wdata;
        default: ;
      endcase
  // Lane 0 ids mirrored only while the config strobe stands
  always_ff @(posedge clock or posedge rst)
    if (rst)
      {dev_r, bank_r} <= '0;
    else if (link_cfg.valid)
      {dev_r, bank_r} <= {link_cfg.device_ident, link_cfg.bank_ident};
  // Out-of-range channels never compare, so they are kept out of hit
  assign sel = sample_in[(ctrl_r[3:2] * SAMPLES + ctrl_r[7:4]) * 16 +: 16];
  assign hit = ctrl_r[0] && sample_valid && ctrl_r[3:2] < CHANNELS && sel != {hi_r, lo_r};
  assign f = check_mismatch_flag;
  assign rd_only = reg_req.rd && !reg_req.wr;
  always_comb
    for (int n = 0; n < LANES; n++)
      mask[n*WORD +: WORD] = {WORD{inv_r[n]}};
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_mismatch_sets: assert property (hit |=> f)
    else $error("flag not raised on mismatch");
  a_disabled_quiet: assert property (!ctrl_r[0] && !f |=> !f)
    else $error("flag raised while disabled");
  a_flag_latched: assert property (f && !ctrl_r[1] |=> f)
    else $error("flag dropped without clear");
  a_clear_wipes: assert property (ctrl_r[1] && !hit |=> !f)
    else $error("clear left flag set");
  a_flag_readback: assert property (reg_req.rd && reg_req.addr == OFS_CHECK_RESULT
    ##1 $stable(f) |-> reg_rdata == {7'h00, f}) else $error("result read wrong");
  a_low_readback: assert property (rd_only && reg_req.addr == OFS_REF_LOW
    |=> reg_rdata == lo_r) else $error("low byte read wrong");
  a_high_readback: assert property (rd_only && reg_req.addr == OFS_REF_HIGH
    |=> reg_rdata == hi_r) else $error("high byte read wrong");
  a_lane_invert: assert property (!$past(rst)
    |-> lane_out == ($past(lane_in) ^ $past(mask))) else $error("lane inversion wrong");
  a_device_ident: assert property (reg_req.rd && reg_req.addr == OFS_DEVICE_IDENT
    && !link_cfg.valid |=> reg_rdata == dev_r) else $error("device id read wrong");
  a_bank_ident: assert property (reg_req.rd && reg_req.addr == OFS_BANK_IDENT
    && !link_cfg.valid |=> reg_rdata == bank_r) else $error("bank id read wrong");
endmodule
bind serdes_rx_sample_check_and_link_id rx_check_props #(.LANES(LANES), .WORD(WORD),
  .CHANNELS(CHANNELS), .SAMPLES(SAMPLES)) props_i (.clock(clock), .rst(rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .lane_in(lane_in), .lane_out(lane_out),
  .sample_valid(sample_valid), .sample_in(sample_in), .link_cfg(link_cfg),
  .check_mismatch_flag(check_mismatch_flag));

/* testbench/link_tx_model.sv */
// Link transmitter model: lane words, converter samples and lane 0 ids
`timescale 1ns/100ps
module link_tx_model #(
  parameter logic [7:0] DEV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] BANK_CODE = 8'h02 // Arbitrary value
) (
  input wire logic clock,
  input wire logic ilas,
  input wire logic [15:0] fill,
  input wire logic [5:0] mark_pos,
  output logic [319:0] lane_in,
  output logic sample_valid,
  output logic [1023:0] sample_in,
  output rx_check_pkg::link_cfg_s link_cfg
);
  import rx_check_pkg::*;
  // Lane words move every cycle, so stale output data cannot pass
  initial
    lane_in = {10{32'h9E3779B9}};
  always @(negedge clock)
    lane_in <= {lane_in[318:0], lane_in[319] ^ lane_in[313]};
  // Every slot carries the fill word, the marked slot its inverse
  always_comb
  begin
    sample_in = {64{fill}};
    sample_in[mark_pos*16 +: 16] = ~fill;
  end
  assign sample_valid = 1'b1;
  // Ids stand only with the strobe; otherwise the lines show their inverse
  assign link_cfg = '{ilas, ilas ? DEV_CODE : ~DEV_CODE,
    ilas ? BANK_CODE : ~BANK_CODE};
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the receive check block
`timescale 1ns/100ps
module tb_top;
  import rx_check_pkg::*;
  localparam logic [7:0] DEV_CODE = 8'h5A; // Arbitrary value
  localparam logic [7:0] BANK_CODE = 8'hC3; // Arbitrary value
  logic clock = 0;
  logic rst = 1;
  logic ilas = 0;
  logic [15:0] fill = 16'h1234;
  logic [5:0] mark_pos = 6'h00;
  reg_req_s reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid, sample_valid, check_mismatch_flag;
  logic [319:0] lane_in, lane_out, m;
  logic [1023:0] sample_in;
  link_cfg_s link_cfg;
  int fail_count = 0;
  int checked = 0;
  initial
    forever #4 clock = ~clock;
  link_tx_model #(.DEV_CODE(DEV_CODE), .BANK_CODE(BANK_CODE)) tx (.clock(clock), .ilas(ilas),
    .fill(fill), .mark_pos(mark_pos), .lane_in(lane_in), .sample_valid(sample_valid),
    .sample_in(sample_in), .link_cfg(link_cfg));
  serdes_rx_sample_check_and_link_id DUT (.clock(clock), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lane_in(lane_in), .lane_out(lane_out),
    .sample_valid(sample_valid), .sample_in(sample_in), .link_cfg(link_cfg),
    .check_mismatch_flag(check_mismatch_flag));
  // *****
  // Bus and compare tasks
  // *****
  task chk(input string what, input logic [319:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clock);
    reg_req <= '0;
  endtask
  // Answer stands one cycle, so it is judged at the next falling edge
  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    reg_req <= '0;
    chk("read valid", reg_rvalid, 1'b1);
    chk($sformatf("register %h", a), reg_rdata, exp);
  endtask
  task flag(input logic exp);
    repeat (3) @(negedge clock);
    chk("mismatch flag", check_mismatch_flag, exp);
  endtask
  // *****
  // Scenarios
  // *****
  task reset_values();
    static logic [11:0] map[8] = '{OFS_CHECK_CONTROL, OFS_REF_LOW, OFS_REF_HIGH, OFS_CHECK_RESULT,
      OFS_LANE_INVERT, OFS_DEVICE_IDENT, OFS_BANK_IDENT, 12'h333};
    foreach (map[i])
      rd(map[i], 8'h00);
  endtask
  task access_kinds();
    wr(OFS_REF_LOW, 8'h34);
    wr(OFS_REF_HIGH, 8'h12);
    wr(OFS_CHECK_RESULT, 8'hFF);
    wr(OFS_DEVICE_IDENT, 8'hFF);
    rd(OFS_REF_LOW, 8'h34);
    rd(OFS_REF_HIGH, 8'h12);
    rd(OFS_CHECK_RESULT, 8'h00);
    rd(OFS_DEVICE_IDENT, 8'h00);
  endtask
  task lanes();
    static logic [7:0] pat[3] = '{8'hA5, 8'h01, 8'h80};
    foreach (pat[k])
    begin
      wr(OFS_LANE_INVERT, pat[k]);
      rd(OFS_LANE_INVERT, pat[k]);
      for (int n = 0; n < 8; n++)
        m[n*40 +: 40] = {40{pat[k][n]}};
      @(posedge clock);
      #1;
      chk("lane out", lane_out, lane_in ^ m);
    end
  endtask
  // Each channel code with sample 0, 5, 10 and 15 marked as the odd one
  task channel_walk();
    logic [3:0] s;
    for (int c = 0; c < 4; c++)
    begin
      // Marked slot moves only on a falling edge
      @(negedge clock);
      s = 4'(c * 5);
      mark_pos <= {2'(c), s};
      wr(OFS_CHECK_CONTROL, {s, 2'(c), 2'b00});
      flag(0);
      wr(OFS_CHECK_CONTROL, {s, 2'(c ^ 1), 2'b01});
      flag(0);
      wr(OFS_CHECK_CONTROL, {s, 2'(c), 2'b01});
      flag(1);
      rd(OFS_CHECK_RESULT, 8'h01);
      wr(OFS_CHECK_CONTROL, {s, 2'(c ^ 1), 2'b01});
      flag(1);
      wr(OFS_CHECK_CONTROL, {s, 2'(c ^ 1), 2'b11});
      flag(0);
    end
  endtask
  task high_byte();
    mark_pos <= 6'h3F;
    wr(OFS_CHECK_CONTROL, 8'h01);
    flag(0);
    wr(OFS_REF_HIGH, 8'h13);
    flag(1);
    wr(OFS_REF_HIGH, 8'h12);
    wr(OFS_CHECK_CONTROL, 8'h03);
    flag(0);
  endtask
  task link_ids();
    @(negedge clock);
    ilas <= 1'b1;
    @(negedge clock);
    ilas <= 1'b0;
    rd(OFS_DEVICE_IDENT, DEV_CODE);
    rd(OFS_BANK_IDENT, BANK_CODE);
  endtask
  task end_of_test();
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clock);
    rst <= 1'b0;
    reset_values();
    access_kinds();
    lanes();
    channel_walk();
    high_byte();
    link_ids();
    end_of_test();
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule
